// [common/pao_pkg.sv]
package pao_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CLK      = 8'h04;
  localparam logic [7:0] OFS_ACC_L    = 8'h08;
  localparam logic [7:0] OFS_ACC_H    = 8'h0c;
  localparam logic [7:0] OFS_ACC_U    = 8'h10;
  localparam logic [7:0] OFS_STEP_L   = 8'h14;
  localparam logic [7:0] OFS_STEP_H   = 8'h18;
  localparam logic [7:0] OFS_STEP_U   = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // widths
  localparam int unsigned ACC_W    = 20;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned UPPER_W  = 4;
  localparam int unsigned PW_CNT_W = 7;
  localparam int unsigned SRC_N    = 5;
  localparam int unsigned IRQ_W    = 1;

  // reset values and field positions
  localparam logic [7:0]       RST_BYTE    = 8'h00;
  localparam logic [7:0]       RST_STEP_L  = 8'h01;
  localparam logic [IRQ_W-1:0] IRQ_OVF     = 1'h1;
  localparam int unsigned      WR_LANE     = 0;

  // accumulator clock source codes
  typedef enum logic [2:0] {
    PAO_SRC_SYS  = 3'h0,
    PAO_SRC_FAST = 3'h1,
    PAO_SRC_LC1  = 3'h2,
    PAO_SRC_LC2  = 3'h3,
    PAO_SRC_LC3  = 3'h4,
    PAO_SRC_LC4  = 3'h5,
    PAO_SRC_RSV6 = 3'h6,
    PAO_SRC_RSV7 = 3'h7
  } pao_src_e;

  // control register layout
  typedef struct packed {
    logic       unit_enable;
    logic       rsv6;
    logic       output_level;
    logic       output_invert;
    logic [2:0] rsv3_1;
    logic       pulse_mode_sel;
  } pao_ctrl_s;

  // clock configuration register layout
  typedef struct packed {
    logic [2:0] pulse_width_sel;
    logic [1:0] rsv4_3;
    pao_src_e   clock_src_sel;
  } pao_clk_s;

endpackage : pao_pkg

// [dv/pao_consumer_model.sv]
`timescale 1ns/10ps
// source lines for the oscillator and a counter of its output changes
module pao_consumer_model (
  input  wire logic       pclk,
  input  wire logic [2:0] run_sel,
  input  wire logic       nco_out,
  output logic      [4:0] lines,
  output int              edges
);
  logic [3:0] div = 4'h0;
  logic       last = 1'b0;
  int         cnt = 0;
  // only the chosen line runs, period 16 pclk; idle lines stay low
  always_ff @(posedge pclk) begin
    div <= div + 4'h1;
    for (int i = 0; i < 5; i++) lines[i] <= (run_sel == 3'(i + 1)) ? div[3] : 1'b0;
  end
  // count output changes
  always_ff @(posedge pclk) begin
    last <= nco_out;
    cnt <= cnt + int'(nco_out !== last);
  end
  assign edges = cnt;
endmodule : pao_consumer_model

// [dv/pao_monitor.sv]
`timescale 1ns/10ps
// bus timing and read-back checks on the top ports
module pao_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read(logic [7:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no answer one cycle after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("answer held longer than one cycle");
  a_err_unmapped_only: assert property (
    s_setup |=> pslverr == (paddr > pao_pkg::OFS_IRQ_MASK))
    else $error("error response does not match address");
  a_rdata_one_byte: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data above the byte lane");
  a_acc_upper_zero: assert property (
    s_read(pao_pkg::OFS_ACC_U) |-> prdata[7:4] == 4'h0)
    else $error("accumulator upper bits not zero");
  a_step_upper_zero: assert property (
    s_read(pao_pkg::OFS_STEP_U) |-> prdata[7:4] == 4'h0)
    else $error("step upper bits not zero");
  a_clk_gap_zero: assert property (s_read(pao_pkg::OFS_CLK) |-> prdata[4:3] == 2'h0)
    else $error("clock config gap bits not zero");
  a_irq_mask_off: assert property (
    psel && penable && pready && pwrite && pstrb[0] && paddr == pao_pkg::OFS_IRQ_MASK
    && !pwdata[0] |=> ##1 !irq)
    else $error("interrupt stays up after masking");
endmodule : pao_monitor

bind pao_top pao_monitor i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq)
);

// [dv/tb_phase_accumulator_oscillator.sv]
`timescale 1ns/10ps
module tb_phase_accumulator_oscillator;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  lines;
  logic [2:0]  run_sel = 3'h0;
  logic        nco_out;
  logic        irq;
  int          edges;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cycles = 0;

  pao_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_fast_osc(lines[0]), .logic_cell_one_out(lines[1]),
    .logic_cell_two_out(lines[2]), .logic_cell_three_out(lines[3]),
    .logic_cell_four_out(lines[4]), .nco_out(nco_out), .irq(irq)
  );
  pao_consumer_model i_model (
    .pclk(pclk), .run_sel(run_sel), .nco_out(nco_out), .lines(lines), .edges(edges)
  );

  // clock
  always #4 pclk = ~pclk;

  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, x);
  endtask : rdc

  task automatic set_step(input logic [19:0] s);
    wr(pao_pkg::OFS_STEP_U, {4'h0, s[19:16]});
    wr(pao_pkg::OFS_STEP_H, s[15:8]);
    wr(pao_pkg::OFS_STEP_L, s[7:0]);
  endtask : set_step

  task automatic watch(input int n, output int e);
    int s;
    repeat (8) @(posedge pclk);
    s = edges;
    repeat (n) @(posedge pclk);
    e = edges - s;
  endtask : watch

  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 10; i++) rdc(8'(4 * i), {31'h0, 8'(4 * i) == pao_pkg::OFS_STEP_L});
    apb(1'b0, 8'h28, 8'h00, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    // only legal source codes are written
    wr(pao_pkg::OFS_CLK, 8'hfd);
    rdc(pao_pkg::OFS_CLK, 32'he5);
    wr(pao_pkg::OFS_STEP_U, 8'hff);
    rdc(pao_pkg::OFS_STEP_U, 32'h0f);
    // a write with the lane 0 strobe low is ignored
    pstrb <= 4'h0;
    wr(pao_pkg::OFS_STEP_H, 8'h55);
    pstrb <= 4'h1;
    rdc(pao_pkg::OFS_STEP_H, 32'h00);
    // accumulator upper byte written while the unit is disabled; bits 7-4 read zero
    wr(pao_pkg::OFS_ACC_U, 8'hff);
    rdc(pao_pkg::OFS_ACC_U, 32'h0f);
    wr(pao_pkg::OFS_ACC_U, 8'h00);
  endtask : t_regs

  // fixed duty, width code ignored, flag and mask
  task automatic t_fixed;
    int e;
    set_step(20'h80000);
    wr(pao_pkg::OFS_CLK, 8'he0);
    wr(pao_pkg::OFS_IRQ_MASK, 8'h01);
    wr(pao_pkg::OFS_CTRL, 8'h80);
    watch(64, e);
    chk(e, 32);
    chk(irq, 1'b1);
    wr(pao_pkg::OFS_CTRL, 8'h00);
    wr(pao_pkg::OFS_IRQ_MASK, 8'h00);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    rdc(pao_pkg::OFS_IRQ_STAT, 32'h1);
    wr(pao_pkg::OFS_IRQ_STAT, 8'h01);
    rdc(pao_pkg::OFS_IRQ_STAT, 32'h0);
    // inverted idle level shows on the pin and in the status bit
    wr(pao_pkg::OFS_CTRL, 8'h10);
    repeat (2) @(posedge pclk);
    chk(nco_out, 1'b1);
    rdc(pao_pkg::OFS_CTRL, 32'h30);
    wr(pao_pkg::OFS_CTRL, 8'h00);
  endtask : t_fixed

  // pulse width per code, overflow every 256 ticks
  task automatic t_pulse;
    int n;
    int w;
    set_step(20'h01000);
    for (int c = 0; c < 8; c++) begin
      wr(pao_pkg::OFS_CTRL, 8'h00);
      wr(pao_pkg::OFS_CLK, {3'(c), 5'h00});
      wr(pao_pkg::OFS_CTRL, 8'h81);
      n = 0;
      w = 0;
      while (nco_out !== 1'b1 && n < 600) begin
        @(posedge pclk);
        n++;
      end
      while (nco_out === 1'b1 && w < 600) begin
        @(posedge pclk);
        w++;
      end
      chk(w, 1 << c);
    end
  endtask : t_pulse

  // each external source code 1 to 5; reserved codes are never written
  task automatic t_src;
    int e;
    // leave pulse mode before the overflow period gets short
    wr(pao_pkg::OFS_CTRL, 8'h00);
    set_step(20'h80000);
    wr(pao_pkg::OFS_CTRL, 8'h80);
    for (int c = 1; c < 6; c++) begin
      run_sel <= 3'(c);
      wr(pao_pkg::OFS_CLK, 8'(c));
      watch(320, e);
      chk(32'(e != 0), 32'h1);
      wr(pao_pkg::OFS_CLK, 8'((c % 5) + 1));
      watch(320, e);
      chk(e, 0);
    end
  endtask : t_src

  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fixed();
    t_pulse();
    t_src();
    finish_test();
  end
endmodule : tb_phase_accumulator_oscillator

// [rtl/pao_sync.sv]
`timescale 1ns/10ps
// three-stage synchroniser; a change counts once stages two and three agree
module pao_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // shift chain, first stage read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // accept a bit only when the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  end

endmodule : pao_sync

// [rtl/pao_top.sv]
`timescale 1ns/10ps
// Behaviour
// - pulse mode holds output active for 2**code input periods, 1 to 128.
// - pulse width code only matters in pulse mode, ignored in fixed duty.
// - source code 0 system clock, 1 fast oscillator, 2-5 logic cells 1-4.
// - 20-bit accumulator over three bytes; upper byte bits 7-4 read zero.
// - accumulator runs freely; multi-byte reads are not made coherent.
// - 20-bit step from three bytes; upper byte bits 7-4 read zero.
// - step double-buffered, loaded on next falling source edge after low write.
// - clock configuration bits 4 and 3 always read zero.
// - each rising source edge adds buffered step, carry on overflow.
// - fixed duty mode toggles output on every overflow.
// - pulse mode drives output active from overflow edge for chosen width.
// - every overflow sets a sticky flag until software clears it.
module pao_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        internal_fast_osc,
  input  wire logic        logic_cell_one_out,
  input  wire logic        logic_cell_two_out,
  input  wire logic        logic_cell_three_out,
  input  wire logic        logic_cell_four_out,
  output logic             nco_out,
  output logic             irq
);

  // local copy of the width counter size, used by the size cast below
  localparam int unsigned PW_CNT_W = pao_pkg::PW_CNT_W;

  // register state
  pao_pkg::pao_ctrl_s                ctrl;
  pao_pkg::pao_clk_s                 clk_cfg;
  logic [pao_pkg::ACC_W-1:0]         phase_accumulator;
  logic [pao_pkg::BYTE_W-1:0]        step_low;
  logic [pao_pkg::BYTE_W-1:0]        step_high;
  logic [pao_pkg::UPPER_W-1:0]       step_upper;
  logic [pao_pkg::ACC_W-1:0]         increment_working_buffer;
  logic                              load_pend;
  logic [pao_pkg::IRQ_W-1:0]         irq_stat;
  logic [pao_pkg::IRQ_W-1:0]         irq_mask;

  // output path state
  logic                              out_raw;
  logic [pao_pkg::PW_CNT_W-1:0]      pulse_left;

  // source clock handling
  logic [pao_pkg::SRC_N-1:0]         src_level;
  logic                              sel_lvl;
  logic                              sel_lvl_q;
  logic                              tick_rise;
  logic                              tick_fall;

  // bus decode
  logic                              wr_en;
  logic                              rd_setup;
  logic                              addr_ok;
  logic [pao_pkg::BYTE_W-1:0]        rd_byte;
  logic [pao_pkg::ACC_W-1:0]         phase_increment;
  logic [pao_pkg::ACC_W:0]           next_sum;
  logic                              accumulator_carry;

  // pick the level of the selected external source
  function automatic logic pick_src(
    input pao_pkg::pao_src_e          sel,
    input logic [pao_pkg::SRC_N-1:0]  lvl
  );
    logic r;
    r = 1'b0;
    unique case (sel)
      pao_pkg::PAO_SRC_FAST: r = lvl[0];
      pao_pkg::PAO_SRC_LC1:  r = lvl[1];
      pao_pkg::PAO_SRC_LC2:  r = lvl[2];
      pao_pkg::PAO_SRC_LC3:  r = lvl[3];
      pao_pkg::PAO_SRC_LC4:  r = lvl[4];
      default:               r = 1'b0;
    endcase
    return r;
  endfunction : pick_src

  // test whether the current transfer writes a given offset
  function automatic logic hit(
    input logic [7:0] ofs
  );
    return wr_en && (paddr == ofs);
  endfunction : hit

  pao_sync #(
    .W (pao_pkg::SRC_N)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     ({logic_cell_four_out, logic_cell_three_out,
               logic_cell_two_out, logic_cell_one_out,
               internal_fast_osc}),
    .level   (src_level)
  );

  assign sel_lvl = pick_src(clk_cfg.clock_src_sel, src_level);

  // delayed copy of the selected level for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_lvl_q <= 1'b0;
    end else begin
      sel_lvl_q <= sel_lvl;
    end
  end

  // system clock ticks every cycle, others on edges
  always_comb begin
    if (clk_cfg.clock_src_sel == pao_pkg::PAO_SRC_SYS) begin
      tick_rise = 1'b1;
      tick_fall = 1'b1;
    end else begin
      tick_rise = sel_lvl & ~sel_lvl_q;
      tick_fall = ~sel_lvl & sel_lvl_q;
    end
  end

  // apb phases: write at access edge, read data set up in setup cycle
  assign wr_en    = psel & penable & pready & pwrite & pstrb[pao_pkg::WR_LANE];
  assign rd_setup = psel & ~penable;

  // address decode
  always_comb begin
    addr_ok = 1'b1;
    unique case (paddr)
      pao_pkg::OFS_CTRL:     rd_byte = ctrl;
      pao_pkg::OFS_CLK:      rd_byte = clk_cfg;
      pao_pkg::OFS_ACC_L:    rd_byte = phase_accumulator[7:0];
      pao_pkg::OFS_ACC_H:    rd_byte = phase_accumulator[15:8];
      pao_pkg::OFS_ACC_U:    rd_byte = {4'h0, phase_accumulator[19:16]};
      // step bytes, upper padded with zero
      pao_pkg::OFS_STEP_L:   rd_byte = step_low;
      pao_pkg::OFS_STEP_H:   rd_byte = step_high;
      pao_pkg::OFS_STEP_U:   rd_byte = {4'h0, step_upper};
      pao_pkg::OFS_IRQ_STAT: rd_byte = {7'h00, irq_stat};
      pao_pkg::OFS_IRQ_MASK: rd_byte = {7'h00, irq_mask};
      default: begin
        rd_byte = pao_pkg::RST_BYTE;
        addr_ok = 1'b0;
      end
    endcase
  end

  // ready answers one cycle after setup, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= rd_setup;
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr <= ~addr_ok;
    end else if (pready) begin
      pslverr <= 1'b0;
    end
  end

  // control register; output level bit is status only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= pao_pkg::RST_BYTE;
    end else begin
      if (hit(pao_pkg::OFS_CTRL)) begin
        ctrl.unit_enable    <= pwdata[7];
        ctrl.output_invert  <= pwdata[4];
        ctrl.pulse_mode_sel <= pwdata[0];
      end
      ctrl.output_level <= nco_out;
    end
  end

  // clock configuration, bits 4 and 3 never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cfg <= pao_pkg::RST_BYTE;
    end else if (hit(pao_pkg::OFS_CLK)) begin
      clk_cfg.pulse_width_sel <= pwdata[7:5];
      clk_cfg.clock_src_sel   <= pao_pkg::pao_src_e'(pwdata[2:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_low   <= pao_pkg::RST_STEP_L;
      step_high  <= pao_pkg::RST_BYTE;
      step_upper <= pao_pkg::RST_BYTE[pao_pkg::UPPER_W-1:0];
    end else begin
      if (hit(pao_pkg::OFS_STEP_L)) begin
        step_low <= pwdata[7:0];
      end
      if (hit(pao_pkg::OFS_STEP_H)) begin
        step_high <= pwdata[7:0];
      end
      if (hit(pao_pkg::OFS_STEP_U)) begin
        step_upper <= pwdata[3:0];
      end
    end
  end

  assign phase_increment = {step_upper, step_high, step_low};

  // low byte write arms a load; a new write wins over clearing the pending load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_pend <= 1'b0;
    end else if (hit(pao_pkg::OFS_STEP_L)) begin
      load_pend <= 1'b1;
    end else if (tick_fall || !ctrl.unit_enable) begin
      load_pend <= 1'b0;
    end
  end

  // working buffer follows registers while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      increment_working_buffer <= {12'h000, pao_pkg::RST_STEP_L};
    end else if (!ctrl.unit_enable) begin
      increment_working_buffer <= phase_increment;
    end else if (load_pend && tick_fall) begin
      increment_working_buffer <= phase_increment;
    end
  end

  assign next_sum          = {1'b0, phase_accumulator}
                           + {1'b0, increment_working_buffer};
  assign accumulator_carry = ctrl.unit_enable & tick_rise
                           & next_sum[pao_pkg::ACC_W];

  // accumulator updates freely, bus writes land directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_accumulator <= '0;
    end else if (hit(pao_pkg::OFS_ACC_L)) begin
      phase_accumulator[7:0] <= pwdata[7:0];
    end else if (hit(pao_pkg::OFS_ACC_H)) begin
      phase_accumulator[15:8] <= pwdata[7:0];
    end else if (hit(pao_pkg::OFS_ACC_U)) begin
      phase_accumulator[19:16] <= pwdata[3:0];
    // add on each rising source edge
    end else if (ctrl.unit_enable && tick_rise) begin
      phase_accumulator <= next_sum[pao_pkg::ACC_W-1:0];
    end
  end

  // pulse mode goes active on overflow edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_raw <= 1'b0;
    end else if (!ctrl.unit_enable) begin
      out_raw <= 1'b0;
    end else if (!ctrl.pulse_mode_sel) begin
      if (accumulator_carry) begin
        out_raw <= ~out_raw;
      end
    end else if (accumulator_carry) begin
      out_raw <= 1'b1;
    end else if (tick_rise && out_raw && pulse_left == '0) begin
      out_raw <= 1'b0;
    end
  end

  // width counter loaded with 2**code minus one
  // counter only used in pulse mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_left <= '0;
    end else if (accumulator_carry && ctrl.pulse_mode_sel) begin
      pulse_left <= PW_CNT_W'((8'h01 << clk_cfg.pulse_width_sel) - 8'h01);
    end else if (tick_rise && pulse_left != '0) begin
      pulse_left <= pulse_left - 1'b1;
    end
  end

  // output polarity stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco_out <= 1'b0;
    end else begin
      nco_out <= out_raw ^ ctrl.output_invert;
    end
  end

  // sticky overflow flag, set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      if (hit(pao_pkg::OFS_IRQ_STAT)) begin
        irq_stat <= irq_stat & ~pwdata[pao_pkg::IRQ_W-1:0];
      end
      if (accumulator_carry) begin
        irq_stat <= irq_stat | pao_pkg::IRQ_OVF;
      end
    end
  end

  // interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (hit(pao_pkg::OFS_IRQ_MASK)) begin
      irq_mask <= pwdata[pao_pkg::IRQ_W-1:0];
    end
  end

  // level interrupt from any unmasked flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule : pao_top
